// [dv/status_latch_mask_unit_test.sv]
// Self-checking bench for the status latch and mask unit.
// Assumes the unit alone on a 25 MHz clock, driven over AXI4-Lite.
`timescale 1ns/1ps
`include "status_latch_map.vh"
module status_latch_mask_unit_test;
  reg         mclk, reset, awvalid, wvalid, bready, arvalid, rready, faultValid;
  reg  [11:0] awaddr, araddr;
  reg  [31:0] wdata;
  reg  [3:0]  wstrb;
  reg  [15:0] digitalPins, faultCode;
  reg  [10:0] lowStatus;
  reg  [1:0]  appFlagSet, appFlagClr;
  reg  [33:0] rows [0:4];
  wire        awready, wready, bvalid, arready, rvalid, quickStop, driveShutdown, errorMode;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] liveStatus;
  integer     n_fail, checked, k;

  // Filter step shortened to one cycle so filter depths stay short
  status_latch_mask_unit #(.STEP_CYC(8'h01)) status_latch_mask_unit_i (
    .mclk(mclk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .digitalPins(digitalPins), .lowStatus(lowStatus), .appFlagSet(appFlagSet),
    .appFlagClr(appFlagClr), .faultValid(faultValid), .faultCode(faultCode),
    .liveStatus(liveStatus), .quickStop(quickStop), .driveShutdown(driveShutdown),
    .errorMode(errorMode));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (e !== g) begin
        $display("Error %0s expected %h seen %h", nm, e, g);
        n_fail = n_fail + 1;
      end
    end
  endtask

  // Ready is looked at on the falling edge so the handshake edge is never raced
  task axw(input [9:0] x, input [15:0] d, input [1:0] er);
    reg a, w, ta, tw;
    begin
      @(posedge mclk);
      awaddr <= {x, 2'b00};
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      a = 1'b0;
      w = 1'b0;
      while (!(a && w)) begin
        @(negedge mclk);
        ta = awready && !a;
        tw = wready && !w;
        @(posedge mclk);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
        a = a | ta;
        w = w | tw;
      end
      do @(negedge mclk); while (!bvalid);
      // bready comes one edge late so the held response is exercised
      @(posedge mclk);
      bready <= 1'b1;
      @(negedge mclk);
      chk("bresp", er, bresp);
      @(posedge mclk);
      bready <= 1'b0;
    end
  endtask

  task axr(input [9:0] x, input [15:0] ed, input [1:0] er);
    begin
      @(posedge mclk);
      araddr <= {x, 2'b00};
      arvalid <= 1'b1;
      do @(negedge mclk); while (!arready);
      @(posedge mclk);
      arvalid <= 1'b0;
      do @(negedge mclk); while (!rvalid);
      // rready comes one edge late so the held read data is exercised
      @(posedge mclk);
      rready <= 1'b1;
      @(negedge mclk);
      chk("rdata", {16'h0000, ed}, rdata);
      chk("rresp", er, rresp);
      @(posedge mclk);
      rready <= 1'b0;
    end
  endtask

  task summarize;
    begin
      $display("Checks %0d, failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // Watchdog: the whole sequence needs well under this many cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail = n_fail + 1;
    summarize;
  end

  // Rows: select word, pin levels, expected live bits 13:12
  initial begin
    rows[0] = {16'h0010, 16'h0002, 2'b10};
    rows[1] = {16'h00f0, 16'h8000, 2'b10};
    rows[2] = {16'h0023, 16'h0008, 2'b01};
    rows[3] = {16'h005a, 16'h0420, 2'b11};
    rows[4] = {16'h0000, 16'hfffe, 2'b00};
    {reset, awvalid, wvalid, bready, arvalid, rready, faultValid} = 7'h40;
    {awaddr, araddr, wdata, digitalPins, faultCode} = 'h0;
    {lowStatus, appFlagSet, appFlagClr} = 'h0;
    wstrb = 4'hf;
    n_fail = 0;
    checked = 0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    for (k = 0; k < 5; k = k + 1) axr(10'h19b + k, 16'h0000, `RESP_OKAY);
    axr(10'h1a1, 16'h0000, `RESP_SLVERR);
    axw(10'h1a1, 16'hffff, `RESP_SLVERR);
    for (k = 0; k < 5; k = k + 1) begin
      axw(`IDX_LIMIT_SELECT, rows[k][33:18], `RESP_OKAY);
      @(posedge mclk);
      digitalPins <= rows[k][17:2];
      repeat (8) @(negedge mclk);
      chk("limitBits", rows[k][1:0], liveStatus[13:12]);
    end
    // Filter depth four: a two-cycle glitch is dropped, a steady level is late
    axw(`IDX_LIMIT_SELECT, 16'h0400, `RESP_OKAY);
    @(posedge mclk);
    digitalPins <= 16'h0001;
    repeat (2) @(posedge mclk);
    digitalPins <= 16'h0000;
    repeat (12) @(negedge mclk) chk("glitch", 2'b00, liveStatus[13:12]);
    @(posedge mclk);
    digitalPins <= 16'h0001;
    repeat (5) @(negedge mclk);
    chk("filterLate", 2'b00, liveStatus[13:12]);
    repeat (15) @(negedge mclk);
    chk("filterOn", 2'b11, liveStatus[13:12]);
    @(posedge mclk);
    digitalPins <= 16'h0000;
    repeat (20) @(negedge mclk);
    axr(`IDX_STICKY_STATUS, 16'h3000, `RESP_OKAY);
    // Flags: set, clear, set beats clear
    @(posedge mclk);
    appFlagSet <= 2'b11;
    @(posedge mclk);
    appFlagSet <= 2'b10;
    appFlagClr <= 2'b11;
    @(posedge mclk);
    {appFlagSet, appFlagClr} <= 4'h0;
    repeat (6) @(negedge mclk);
    chk("flags", 2'b10, liveStatus[15:14]);
    axr(`IDX_LIVE_STATUS, 16'h8000, `RESP_OKAY);
    @(posedge mclk);
    appFlagClr <= 2'b10;
    lowStatus <= 11'h005;
    @(posedge mclk);
    appFlagClr <= 2'b00;
    lowStatus <= 11'h000;
    repeat (4) @(negedge mclk);
    chk("flagsOff", 2'b00, liveStatus[15:14]);
    axr(`IDX_STICKY_STATUS, 16'hc005, `RESP_OKAY);
    axr(`IDX_STICKY_STATUS, 16'h0000, `RESP_OKAY);
    // Masks: quick stop, then shutdown winning over it, error mode held
    axw(`IDX_QUICK_MASK, 16'h0002, `RESP_OKAY);
    axw(`IDX_HALT_MASK, 16'h0004, `RESP_OKAY);
    axr(`IDX_QUICK_MASK, 16'h0002, `RESP_OKAY);
    axr(`IDX_HALT_MASK, 16'h0004, `RESP_OKAY);
    @(posedge mclk);
    lowStatus <= 11'h002;
    repeat (4) @(negedge mclk);
    chk("stops", 3'b100, {quickStop, driveShutdown, errorMode});
    @(posedge mclk);
    lowStatus <= 11'h006;
    repeat (4) @(negedge mclk);
    chk("liveStatus", 16'h0006, liveStatus);
    chk("stops", 3'b011, {quickStop, driveShutdown, errorMode});
    @(posedge mclk);
    lowStatus <= 11'h000;
    repeat (4) @(negedge mclk);
    chk("stops", 3'b001, {quickStop, driveShutdown, errorMode});
    // Fault code: latest kept, code without strobe ignored, writes answered OKAY but ignored
    @(posedge mclk);
    faultValid <= 1'b1;
    faultCode <= `FAULT_GENERAL;
    @(posedge mclk);
    faultValid <= 1'b0;
    faultCode <= 16'h7001;
    axr(`IDX_FAULT_CODE, `FAULT_GENERAL, `RESP_OKAY);
    @(posedge mclk);
    faultValid <= 1'b1;
    @(posedge mclk);
    faultValid <= 1'b0;
    faultCode <= 16'h0000;
    axw(`IDX_FAULT_CODE, 16'h1234, `RESP_OKAY);
    axr(`IDX_FAULT_CODE, 16'h7001, `RESP_OKAY);
    // Reset in mid-run clears error mode and the masks
    @(posedge mclk);
    reset <= 1'b1;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chk("afterReset", 3'b000, {quickStop, driveShutdown, errorMode});
    axr(`IDX_HALT_MASK, 16'h0000, `RESP_OKAY);
    summarize;
  end
endmodule // status_latch_mask_unit_test

// [dv/status_latch_monitor.sv]
// Checker for the status latch and mask unit, attached by bind.
// Assumes only the unit's top-level ports; internal masks are not visible.
`timescale 1ns/1ps
module status_latch_monitor #(
  parameter NUM_PINS = 16,
  parameter ADDR_W   = 12
) (
  input wire        mclk,          // Clock
  input wire        reset,         // Sync reset
  input wire        awvalid,       // AW valid
  input wire        awready,       // AW ready
  input wire        wvalid,        // W valid
  input wire        wready,        // W ready
  input wire [1:0]  bresp,         // B response
  input wire        bvalid,        // B valid
  input wire        bready,        // B ready
  input wire        arvalid,       // AR valid
  input wire        arready,       // AR ready
  input wire [31:0] rdata,         // R data
  input wire        rvalid,        // R valid
  input wire        rready,        // R ready
  input wire [1:0]  appFlagSet,    // Flag set
  input wire [1:0]  appFlagClr,    // Flag clear
  input wire [15:0] liveStatus,    // Live word
  input wire        quickStop,     // Quick stop
  input wire        driveShutdown, // Shutdown
  input wire        errorMode      // Error mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Stop outputs: shutdown outranks quick stop and error mode never lets go
  property p_prio; driveShutdown |-> !quickStop; endproperty
  a_prio: assert property (p_prio) else $error("quick stop beside shutdown");
  property p_errset; driveShutdown |=> errorMode; endproperty
  a_errset: assert property (p_errset) else $error("shutdown without error mode");
  property p_errhold; errorMode |=> errorMode; endproperty
  a_errhold: assert property (p_errhold) else $error("error mode dropped");

  // Flag one rises only on a set strobe, flag two falls only on a clear strobe
  property p_flagrise; $rose(liveStatus[14]) |-> $past(appFlagSet[0]) || $past(appFlagSet[0], 2); endproperty
  a_flagrise: assert property (p_flagrise) else $error("flag one rose alone");
  property p_flagfall; $fell(liveStatus[15]) |-> $past(appFlagClr[1]) || $past(appFlagClr[1], 2); endproperty
  a_flagfall: assert property (p_flagfall) else $error("flag two fell alone");

  // Register bus timing, held answers
  property p_rd; arvalid && arready |=> rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  property p_wr; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response not held");

  c_quick: cover property (quickStop && !driveShutdown);
  c_shut: cover property ($rose(driveShutdown));
  c_read: cover property (rvalid && rready);
  c_flags: cover property (liveStatus[15:14] == 2'b11);
endmodule // status_latch_monitor

bind status_latch_mask_unit status_latch_monitor #(.NUM_PINS(NUM_PINS), .ADDR_W(ADDR_W))
  status_latch_monitor_i (.mclk(mclk), .reset(reset), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .appFlagSet(appFlagSet), .appFlagClr(appFlagClr), .liveStatus(liveStatus),
  .quickStop(quickStop), .driveShutdown(driveShutdown), .errorMode(errorMode));

// [verilog/status_latch_map.vh]
// Register indices, field positions, reset values and timing counts of the
// status latch and mask unit. Included by the unit and its test bench; holds no logic.
`ifndef STATUS_LATCH_MAP_VH
`define STATUS_LATCH_MAP_VH

// Register indices; the byte address is four times the index
`define IDX_LIVE_STATUS   10'h1a0
`define IDX_STICKY_STATUS 10'h19b
`define IDX_LIMIT_SELECT  10'h19c
`define IDX_QUICK_MASK    10'h19d
`define IDX_HALT_MASK     10'h19e
`define IDX_FAULT_CODE    10'h19f

// Live status word bit positions
`define BIT_RESERVED      11
`define BIT_FIRST_LIMIT   12
`define BIT_SECOND_LIMIT  13
`define BIT_APP_FLAG_ONE  14
`define BIT_APP_FLAG_TWO  15

// Limit input select fields
`define SEL_FIRST_LSB     0
`define SEL_SECOND_LSB    4
`define FILT_LSB          8

// Reset values, and the general fault code
`define RST_SELECT        16'h0000
`define RST_MASK          16'h0000
`define RST_FAULT         16'h0000
`define FAULT_GENERAL     16'h0001

// Filter time base: one filter step per this many ns
`define FILT_STEP_NS      1000
`define CLK_PERIOD_NS     40
`define FILT_STEP_CYC     8'h19   // 1000 ns step at a 40 ns clock

// AXI responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// [verilog/status_latch_mask_unit.v]
// Status latch and mask unit: live status word, sticky status, limit input
// mirroring with filter, quick-stop and shutdown masks, last fault code.
// Assumes an AXI4-Lite master on mclk, asynchronous digital input pins,
// and event/fault sources on mclk.
`timescale 1ns/1ps
`include "status_latch_map.vh"

module status_latch_mask_unit #(
  parameter       NUM_PINS  = 16,                     // Digital input pins
  parameter       ADDR_W    = 12,                     // AXI address width
  parameter [7:0] STEP_CYC  = `FILT_STEP_CYC                  // Cycles per filter step
) (
  input  wire                mclk,         // System clock, 25 MHz
  input  wire                reset,        // Synchronous reset, active high
  // AXI4-Lite slave
  input  wire [ADDR_W-1:0]   awaddr,       // Write address
  input  wire                awvalid,      // Write address valid
  output wire                awready,      // Write address ready
  input  wire [31:0]         wdata,        // Write data
  input  wire [3:0]          wstrb,        // Write byte strobes
  input  wire                wvalid,       // Write data valid
  output wire                wready,       // Write data ready
  output wire [1:0]          bresp,        // Write response
  output wire                bvalid,       // Write response valid
  input  wire                bready,       // Write response ready
  input  wire [ADDR_W-1:0]   araddr,       // Read address
  input  wire                arvalid,      // Read address valid
  output wire                arready,      // Read address ready
  output wire [31:0]         rdata,        // Read data
  output wire [1:0]          rresp,        // Read response
  output wire                rvalid,       // Read data valid
  input  wire                rready,       // Read data ready
  // Drive side
  input  wire [NUM_PINS-1:0] digitalPins,  // Asynchronous digital input pins
  input  wire [10:0]         lowStatus,    // Live status bits 0..10
  input  wire [1:0]          appFlagSet,   // Event handler set of flags one, two
  input  wire [1:0]          appFlagClr,   // Event handler clear of flags one, two
  input  wire                faultValid,   // Pulse: new fault code present
  input  wire [15:0]         faultCode,    // Fault code with faultValid
  output wire [15:0]         liveStatus,   // Registered live status word
  output wire                quickStop,    // Quick stop request, level
  output wire                driveShutdown,// Driver off, error mode, level
  output wire                errorMode     // Error mode entered, sticky
);

  // Last count of the filter divider; a zero step behaves as a one-cycle step
  localparam [7:0] STEP_LAST = (STEP_CYC > 8'h00) ? STEP_CYC - 8'h01 : 8'h00;

  // Register file and status state
  reg  [15:0]         stickyFf;
  reg  [15:0]         selectFf;
  reg  [15:0]         quickMaskFf;
  reg  [15:0]         haltMaskFf;
  reg  [15:0]         faultFf;
  reg  [1:0]          appFlagFf;
  reg  [15:0]         liveFf;
  reg                 quickFf;
  reg                 shutFf;
  reg                 errModeFf;
  reg  [NUM_PINS-1:0] pinMetaFf;
  reg  [NUM_PINS-1:0] pinSyncFf;
  reg  [7:0]          stepCntFf;
  reg                 stepTickFf;
  // Filtered limit levels and the unregistered live word
  wire [1:0]          limitLevel;
  wire [15:0]         liveWord;

  // Bus slave state
  reg                 awHeldFf;
  reg                 wHeldFf;
  reg  [ADDR_W-1:0]   awAddrFf;
  reg  [31:0]         wDataFf;
  reg  [3:0]          wStrbFf;
  reg                 awReadyFf;
  reg                 wReadyFf;
  reg                 bValidFf;
  reg  [1:0]          bRespFf;
  reg                 arReadyFf;
  reg                 rValidFf;
  reg  [31:0]         rDataFf;
  reg  [1:0]          rRespFf;

  // Two-stage synchroniser; only the second stage feeds the selectors
  // Pins are asynchronous; one flop alone could pass metastability onward
  always @(posedge mclk) begin
    if (reset) begin
      pinMetaFf <= {NUM_PINS{1'b0}};
      pinSyncFf <= {NUM_PINS{1'b0}};
    end else begin
      pinMetaFf <= digitalPins;
      pinSyncFf <= pinMetaFf;
    end
  end

  // Filter time base; a one-cycle enable rather than a second clock
  // The counter restarts at STEP_LAST, so a tick comes every STEP_CYC cycles;
  // with a step of one cycle the tick stays high
  always @(posedge mclk) begin
    if (reset) begin
      stepCntFf  <= 8'h00;
      stepTickFf <= 1'b0;
    end else if (stepCntFf >= STEP_LAST) begin
      stepCntFf  <= 8'h00;
      stepTickFf <= 1'b1;
    end else begin
      stepCntFf  <= stepCntFf + 8'h01;
      stepTickFf <= 1'b0;
    end
  end

  // Per limit input: select a pin, then require it stable for N steps
  // An index beyond the pin count reads as a low input
  // The count restarts whenever raw and filtered levels agree, so only
  // an unbroken run of disagreeing ticks moves the level
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gLimit
      wire [3:0] pinIdx = selectFf[4*g+3:4*g];
      wire       rawLvl = (pinIdx < NUM_PINS) ? pinSyncFf[pinIdx] : 1'b0;
      wire [7:0] depth  = selectFf[`FILT_LSB+7:`FILT_LSB];
      reg  [7:0] stableFf;
      reg        levelFf;
      // Larger depth rejects longer glitches but delays the edge longer
      always @(posedge mclk) begin
        if (reset) begin
          stableFf <= 8'h00;
          levelFf  <= 1'b0;
        end else if (rawLvl == levelFf) begin
          stableFf <= 8'h00;
        end else if (depth == 8'h00) begin
          levelFf  <= rawLvl;
          stableFf <= 8'h00;
        end else if (stepTickFf) begin
          if (stableFf + 8'h01 >= depth) begin
            levelFf  <= rawLvl;
            stableFf <= 8'h00;
          end else begin
            stableFf <= stableFf + 8'h01;
          end
        end
      end
      assign limitLevel[g] = levelFf;
    end
  endgenerate

  // Application flags: only the event handler moves them, set wins
  // A set and a clear in one cycle leave the flag set
  always @(posedge mclk) begin
    if (reset) begin
      appFlagFf <= 2'b00;
    end else begin
      appFlagFf <= (appFlagFf & ~appFlagClr) | appFlagSet;
    end
  end

  // Live word; reserved bit 11 always reads zero
  // Bits 0..10 come from the drive on this clock, so they need no synchroniser
  assign liveWord = {appFlagFf[1], appFlagFf[0],
                     limitLevel[1],
                     limitLevel[0], 1'b0, lowStatus};

  // Mask comparison every cycle; shutdown suppresses quick stop
  // Compared against the unregistered word so the stop outputs change on the
  // same edge as liveStatus; error mode is left only through reset
  always @(posedge mclk) begin
    if (reset) begin
      liveFf    <= 16'h0000;
      quickFf   <= 1'b0;
      shutFf    <= 1'b0;
      errModeFf <= 1'b0;
    end else begin
      liveFf    <= liveWord;
      shutFf    <= |(liveWord & haltMaskFf);
      quickFf   <= |(liveWord & quickMaskFf) &
                   ~|(liveWord & haltMaskFf);
      if (|(liveWord & haltMaskFf)) begin
        errModeFf <= 1'b1;
      end
    end
  end

  // Decode helpers
  // Only address bits 11:2 are decoded; higher bits alias onto the map
  wire [9:0] wrIdx   = awAddrFf[11:2];
  wire [9:0] rdIdx   = araddr[11:2];
  wire       doWrite = awHeldFf & wHeldFf & ~bValidFf;
  wire       rdTake  = arvalid & arReadyFf;
  wire       rdClear = rdTake & (rdIdx == `IDX_STICKY_STATUS);
  wire       wrMapped = (wrIdx == `IDX_LIMIT_SELECT) | (wrIdx == `IDX_QUICK_MASK) |
                        (wrIdx == `IDX_HALT_MASK) | (wrIdx == `IDX_STICKY_STATUS) |
                        (wrIdx == `IDX_FAULT_CODE) | (wrIdx == `IDX_LIVE_STATUS);

  // Byte-lane merge for 16-bit registers
  function [15:0] merge;
    input [15:0] old;
    input [31:0] dat;
    input [3:0]  stb;
    begin
      merge = {stb[1] ? dat[15:8] : old[15:8], stb[0] ? dat[7:0] : old[7:0]};
    end
  endfunction

  // Sticky copy: live bits set, a read clears, a set in that cycle survives
  // The read returns the old value; a bit that sets on the clearing edge
  // is kept for the next read rather than lost
  always @(posedge mclk) begin
    if (reset) begin
      stickyFf <= 16'h0000;
    end else begin
      stickyFf <= (rdClear ? 16'h0000 : stickyFf) | liveWord;
    end
  end

  // Latest fault code held until the next one
  // A later code overwrites the earlier one; only reset returns it to zero
  always @(posedge mclk) begin
    if (reset) begin
      faultFf <= `RST_FAULT;
    end else if (faultValid) begin
      faultFf <= faultCode;
    end
  end

  // Writable configuration registers
  // Byte lanes 2 and 3 are ignored since every register is 16 bits wide
  always @(posedge mclk) begin
    if (reset) begin
      selectFf    <= `RST_SELECT;
      quickMaskFf <= `RST_MASK;
      haltMaskFf  <= `RST_MASK;
    end else if (doWrite) begin
      if (wrIdx == `IDX_LIMIT_SELECT) begin
        selectFf <= merge(selectFf, wDataFf, wStrbFf);
      end
      if (wrIdx == `IDX_QUICK_MASK) begin
        quickMaskFf <= merge(quickMaskFf, wDataFf, wStrbFf);
      end
      if (wrIdx == `IDX_HALT_MASK) begin
        haltMaskFf <= merge(haltMaskFf, wDataFf, wStrbFf);
      end
    end
  end

  // Write channel: address and data taken in either order, then answer
  // One write at a time; readies stay low until the response is taken
  always @(posedge mclk) begin
    if (reset) begin
      awHeldFf  <= 1'b0;
      wHeldFf   <= 1'b0;
      awAddrFf  <= {ADDR_W{1'b0}};
      wDataFf   <= 32'h00000000;
      wStrbFf   <= 4'h0;
      awReadyFf <= 1'b0;
      wReadyFf  <= 1'b0;
      bValidFf  <= 1'b0;
      bRespFf   <= `RESP_OKAY;
    end else begin
      if (doWrite) begin
        awHeldFf  <= 1'b0;
        wHeldFf   <= 1'b0;
        bValidFf  <= 1'b1;
        // Read-only targets accept silently; unmapped ones return an error
        bRespFf   <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (awvalid & awReadyFf) begin
          awHeldFf <= 1'b1;
          awAddrFf <= awaddr;
        end
        if (wvalid & wReadyFf) begin
          wHeldFf <= 1'b1;
          wDataFf <= wdata;
          wStrbFf <= wstrb;
        end
        if (bValidFf & bready) begin
          bValidFf <= 1'b0;
        end
      end
      // Ready drops the cycle after a capture, returns once answered
      awReadyFf <= ~(awHeldFf | (awvalid & awReadyFf)) & ~doWrite & ~bValidFf;
      wReadyFf  <= ~(wHeldFf | (wvalid & wReadyFf)) & ~doWrite & ~bValidFf;
    end
  end

  // Read channel: one outstanding read, data one cycle after the address
  // The upper half of the data bus always reads zero
  always @(posedge mclk) begin
    if (reset) begin
      arReadyFf <= 1'b0;
      rValidFf  <= 1'b0;
      rDataFf   <= 32'h00000000;
      rRespFf   <= `RESP_OKAY;
    end else if (rdTake) begin
      arReadyFf <= 1'b0;
      rValidFf  <= 1'b1;
      rRespFf   <= `RESP_OKAY;
      case (rdIdx)
        `IDX_LIVE_STATUS:   rDataFf <= {16'h0000, liveWord};
        `IDX_STICKY_STATUS: rDataFf <= {16'h0000, stickyFf};
        `IDX_LIMIT_SELECT:  rDataFf <= {16'h0000, selectFf};
        `IDX_QUICK_MASK:    rDataFf <= {16'h0000, quickMaskFf};
        `IDX_HALT_MASK:     rDataFf <= {16'h0000, haltMaskFf};
        `IDX_FAULT_CODE:    rDataFf <= {16'h0000, faultFf};
        default: begin
          rDataFf <= 32'h00000000;
          rRespFf <= `RESP_SLVERR;
        end
      endcase
    end else if (rValidFf & rready) begin
      rValidFf  <= 1'b0;
      arReadyFf <= 1'b1;
    end else if (~rValidFf) begin
      arReadyFf <= 1'b1;
    end
  end

  // Every output comes straight from a flop
  assign awready       = awReadyFf;
  assign wready        = wReadyFf;
  assign bvalid        = bValidFf;
  assign bresp         = bRespFf;
  assign arready       = arReadyFf;
  assign rvalid        = rValidFf;
  assign rdata         = rDataFf;
  assign rresp         = rRespFf;
  assign liveStatus    = liveFf;
  assign quickStop     = quickFf;
  assign driveShutdown = shutFf;
  assign errorMode     = errModeFf;

endmodule // status_latch_mask_unit
